// ### src/scc_ctrl.sv
// speculation level tracking, checkpoints, store hold-back and fp dispatch
// Notes on behaviour
// RULE1: at most four speculation levels, each from a predicted branch or fp op.
// RULE2: fp instructions open speculation through the same checkpoint slots as branches.
// RULE3: on predicted fetch, checkpoint state, bump level counter, follow predicted path.
// RULE4: every resolved branch lowers the level counter by one.
// RULE5: correctly predicted branch just frees its checkpoint slot, no restore.
// RULE6: mispredict drives correct fetch address and restored state next clock.
// RULE7: speculative stores wait in buffers until all governing levels resolve.
// RULE8: no new level opens while the counter already stands at four.
// RULE9: any exception or fault halts further speculation.
// RULE10: speculation halts while the store buffers have no free entry.
// RULE11: writing non-checkpointed state halts speculation.
// RULE12: fp instructions go to the x pipe only, never the y pipe.
// RULE13: x pipe address stages check mmu faults and fetch fp memory operands.
// RULE14: fault-free fp op is checkpointed and queued in second_address_calc_stage.
// RULE15: fpu queue holds at most four pending fp instructions.
// RULE16: exceptions are signalled and writes issued in program order.
// RULE17: each fpu completion lowers the level and frees its checkpoint slot.
// RULE18: four store buffers absorb speculative fp stores without stalling.
// RULE19: mispredict flushes four clocks from execute_stage, five from write_back_stage.
// RULE20: level counter stays in zero to four and resets to zero.
// RULE21: mispredict also discards all younger levels and adjusts the counter.
`timescale 1ns/10ps
module scc_ctrl
(
    input wire logic i_sys_clk,
    input wire logic i_srst,
    input wire logic i_ce,
    input wire logic i_br_open,
    input wire scc_pkg::scc_ckpt_t i_ckpt_state,
    input wire logic i_fp_decoded,
    input wire logic i_fp_mem_operand,
    input wire logic i_fp_ac2,
    input wire logic i_fp_mmu_exc,
    input wire logic [31:0] i_fp_instr,
    input wire scc_pkg::scc_resolve_t i_res,
    input wire logic i_fpu_done,
    input wire logic i_fpu_exc,
    input wire logic i_int_exc,
    input wire logic i_noncp_write,
    input wire logic i_st_valid,
    input wire scc_pkg::scc_store_t i_st,
    output logic o_open_ack,
    output logic [scc_pkg::SLOT_W-1:0] o_open_slot,
    output logic [scc_pkg::LEVEL_W-1:0] o_spec_level,
    output logic o_spec_stall,
    output logic o_restore_valid,
    output scc_pkg::scc_ckpt_t o_restore,
    output logic [31:0] o_fetch_addr,
    output logic o_flush,
    output logic o_fp_pipe_x,
    output logic o_fp_opnd_req,
    output logic o_fpq_push,
    output logic [31:0] o_fpq_instr,
    output logic o_exc_signal,
    output logic o_mem_wr,
    output scc_pkg::scc_store_t o_mem_st,
    output logic o_st_ready
);

    function automatic logic [scc_pkg::LEVEL_W-1:0] popcnt(input scc_pkg::scc_mask_t m);
        logic [scc_pkg::LEVEL_W-1:0] n;
        n = '0;
        for (int k = 0; k < scc_pkg::NUM_LEVELS; k++)
            n = n + {2'h0, m[k]};
        return n;
    endfunction

    // slots allocated after slot s and before the allocation pointer
    function automatic scc_pkg::scc_mask_t younger(input logic [scc_pkg::SLOT_W-1:0] s,
        input logic [scc_pkg::SLOT_W-1:0] tail, input scc_pkg::scc_mask_t v);
        scc_pkg::scc_mask_t y;
        logic [scc_pkg::SLOT_W-1:0] d;
        logic [scc_pkg::LEVEL_W-1:0] span;
        y = '0;
        span = (tail == s) ? scc_pkg::MAX_LEVEL : {1'b0, tail - s};
        for (int k = 0; k < scc_pkg::NUM_LEVELS; k++)
        begin
            d = k[scc_pkg::SLOT_W-1:0] - s;
            y[k] = v[k] && (d != '0) && ({1'b0, d} < span);
        end
        return y;
    endfunction

    scc_pkg::scc_ckpt_t ck_r [scc_pkg::NUM_LEVELS];
    scc_pkg::scc_mask_t ck_v_r, ck_fp_r;
    logic [scc_pkg::SLOT_W-1:0] tail_r;
    logic [scc_pkg::LEVEL_W-1:0] cnt_r;
    logic halt_r;
    logic [scc_pkg::SLOT_W-1:0] fq_slot_r [scc_pkg::FPQ_DEPTH];
    logic [scc_pkg::SLOT_W-1:0] fq_rd_r;
    logic [scc_pkg::LEVEL_W-1:0] fq_cnt_r;
    scc_pkg::scc_store_t wb_st_r [scc_pkg::WBUF_DEPTH];
    scc_pkg::scc_mask_t wb_dep_r [scc_pkg::WBUF_DEPTH];
    logic [scc_pkg::SLOT_W-1:0] wb_rd_r;
    logic [scc_pkg::LEVEL_W-1:0] wb_cnt_r;
    logic [scc_pkg::PEN_W-1:0] pen_r;
    logic exc_pend_r;

    logic can_open, open_fp, open_br, open_any, res_hit, res_good, res_bad, fp_done, wb_commit, wb_push;
    scc_pkg::scc_mask_t young, free_mask, open_mask;
    logic [scc_pkg::LEVEL_W-1:0] cnt_nxt, fq_drop, wb_drop, fq_cnt_nxt, wb_cnt_nxt;
    logic [scc_pkg::SLOT_W-1:0] fq_wr, wb_wr;

    assign can_open = (cnt_r < scc_pkg::MAX_LEVEL) && !ck_v_r[tail_r] // [RULE1] [RULE8]
        && !halt_r && !i_int_exc && !i_fpu_exc // [RULE9]
        && (wb_cnt_r < scc_pkg::WBUF_MAX) // [RULE10]
        && !i_noncp_write // [RULE11]
        && !res_bad && (pen_r == '0);
    assign open_fp = i_fp_ac2 && !i_fp_mmu_exc && can_open && (fq_cnt_r < scc_pkg::FPQ_MAX); // [RULE14] [RULE15]
    assign open_br = i_br_open && can_open && !open_fp; // [RULE2]
    assign open_any = open_fp || open_br;
    assign res_hit = i_res.valid && ck_v_r[i_res.slot] && !ck_fp_r[i_res.slot];
    assign res_good = res_hit && i_res.correct;
    assign res_bad = res_hit && !i_res.correct;
    assign fp_done = i_fpu_done && (fq_cnt_r != '0);
    assign young = res_bad ? younger(i_res.slot, tail_r, ck_v_r) : '0; // [RULE21]

    always_comb
    begin
        free_mask = '0;
        open_mask = '0;
        if (res_hit)
            free_mask[i_res.slot] = 1'b1; // [RULE4] [RULE5]
        if (fp_done)
            free_mask[fq_slot_r[fq_rd_r]] = 1'b1; // [RULE17]
        free_mask = (free_mask | young) & ck_v_r; // [RULE21]
        if (open_any)
            open_mask[tail_r] = 1'b1;
    end

    assign cnt_nxt = cnt_r + {2'h0, open_any} - popcnt(free_mask); // [RULE3] [RULE20]
    assign fq_drop = popcnt(young & ck_fp_r & ~free_mask) + popcnt(young & ck_fp_r & free_mask)
        - {2'h0, fp_done && young[fq_slot_r[fq_rd_r]]};
    assign fq_cnt_nxt = fq_cnt_r + {2'h0, open_fp} - {2'h0, fp_done} - fq_drop;
    assign fq_wr = fq_rd_r + fq_cnt_r[scc_pkg::SLOT_W-1:0];
    assign wb_commit = (wb_cnt_r != '0) && ((wb_dep_r[wb_rd_r] & ck_v_r) == '0); // [RULE7]
    assign wb_push = i_st_valid && (wb_cnt_r < scc_pkg::WBUF_MAX) && !(res_bad && ck_v_r[i_res.slot]); // [RULE18]
    assign wb_wr = wb_rd_r + wb_cnt_r[scc_pkg::SLOT_W-1:0];

    always_comb
    begin
        wb_drop = '0;
        for (int k = 0; k < scc_pkg::WBUF_DEPTH; k++)
            if (res_bad && (k[scc_pkg::LEVEL_W-1:0] < wb_cnt_r)
                && wb_dep_r[wb_rd_r + k[scc_pkg::SLOT_W-1:0]][i_res.slot])
                wb_drop = wb_drop + 3'h1; // [RULE21]
    end

    assign wb_cnt_nxt = wb_cnt_r + {2'h0, wb_push} - {2'h0, wb_commit} - wb_drop;

    // checkpoint slots and level counter
    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
        begin
            ck_v_r <= '0;
            ck_fp_r <= '0;
            tail_r <= scc_pkg::SLOT_RST;
            cnt_r <= scc_pkg::LEVEL_RST; // [RULE20]
        end
        else if (i_ce)
        begin
            ck_v_r <= (ck_v_r & ~free_mask) | open_mask;
            ck_fp_r <= (ck_fp_r & ~free_mask) | (open_fp ? open_mask : '0);
            if (open_any)
            begin
                ck_r[tail_r] <= i_ckpt_state; // [RULE3]
                tail_r <= tail_r + 2'h1;
            end
            else if (res_bad)
                tail_r <= i_res.slot; // [RULE21]
            cnt_r <= cnt_nxt;
        end
    end

    // halt on faults and non-checkpointed writes until speculation drains
    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
            halt_r <= 1'b0;
        else if (i_ce)
        begin
            if (i_int_exc || i_fpu_exc || i_fp_mmu_exc || i_noncp_write) // [RULE9] [RULE11]
                halt_r <= 1'b1;
            else if (cnt_nxt == '0)
                halt_r <= 1'b0;
        end
    end

    // misprediction restore and refetch penalty
    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
        begin
            o_restore_valid <= 1'b0;
            o_restore <= '0;
            o_fetch_addr <= '0;
            pen_r <= '0;
            o_flush <= 1'b0;
        end
        else if (i_ce)
        begin
            o_restore_valid <= res_bad; // [RULE6]
            if (res_bad)
            begin
                o_restore <= ck_r[i_res.slot];
                o_fetch_addr <= ck_r[i_res.slot].alt_fetch;
                pen_r <= i_res.in_write_back_stage ? scc_pkg::PEN_WRITE_BACK_STAGE
                    : scc_pkg::PEN_EXECUTE_STAGE; // [RULE19]
                o_flush <= 1'b1;
            end
            else
            begin
                pen_r <= (pen_r != '0) ? pen_r - 3'h1 : pen_r;
                o_flush <= (pen_r > 3'h1);
            end
        end
    end

    // fpu queue bookkeeping and dispatch
    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
        begin
            fq_rd_r <= '0;
            fq_cnt_r <= scc_pkg::LEVEL_RST;
            o_fpq_push <= 1'b0;
            o_fpq_instr <= '0;
            o_fp_pipe_x <= 1'b0;
            o_fp_opnd_req <= 1'b0;
        end
        else if (i_ce)
        begin
            o_fp_pipe_x <= i_fp_decoded; // [RULE12]
            o_fp_opnd_req <= i_fp_mem_operand && !i_fp_mmu_exc; // [RULE13]
            o_fpq_push <= open_fp; // [RULE14]
            if (open_fp)
            begin
                o_fpq_instr <= i_fp_instr;
                fq_slot_r[fq_wr] <= tail_r;
            end
            if (fp_done)
                fq_rd_r <= fq_rd_r + 2'h1;
            fq_cnt_r <= fq_cnt_nxt; // [RULE15]
        end
    end

    // integer exceptions wait behind older queued fp work
    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
        begin
            exc_pend_r <= 1'b0;
            o_exc_signal <= 1'b0;
        end
        else if (i_ce)
        begin
            o_exc_signal <= i_fpu_exc || ((i_int_exc || exc_pend_r) && (fq_cnt_r == '0)); // [RULE16]
            exc_pend_r <= (i_int_exc || exc_pend_r) && (fq_cnt_r != '0);
        end
    end

    // store buffer: in-order drain of resolved stores
    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
        begin
            wb_rd_r <= '0;
            wb_cnt_r <= scc_pkg::LEVEL_RST;
            o_mem_wr <= 1'b0;
            o_mem_st <= '0;
            o_st_ready <= 1'b0;
        end
        else if (i_ce)
        begin
            if (wb_push)
            begin
                wb_st_r[wb_wr] <= i_st;
                wb_dep_r[wb_wr] <= ck_v_r & ~free_mask; // [RULE7]
            end
            o_mem_wr <= wb_commit; // [RULE16]
            if (wb_commit)
            begin
                o_mem_st <= wb_st_r[wb_rd_r];
                wb_rd_r <= wb_rd_r + 2'h1;
            end
            wb_cnt_r <= wb_cnt_nxt;
            o_st_ready <= wb_cnt_nxt < scc_pkg::WBUF_MAX; // [RULE18]
        end
    end

    // status outputs
    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
        begin
            o_open_ack <= 1'b0;
            o_open_slot <= scc_pkg::SLOT_RST;
            o_spec_level <= scc_pkg::LEVEL_RST;
            o_spec_stall <= 1'b0;
        end
        else if (i_ce)
        begin
            o_open_ack <= open_any;
            o_open_slot <= tail_r;
            o_spec_level <= cnt_nxt;
            o_spec_stall <= (cnt_nxt == scc_pkg::MAX_LEVEL) || (wb_cnt_nxt == scc_pkg::WBUF_MAX); // [RULE8] [RULE10]
        end
    end

    sequence s_bad_ex;
        i_ce && res_bad && !i_res.in_write_back_stage;
    endsequence
    sequence s_bad_wb;
        i_ce && res_bad && i_res.in_write_back_stage;
    endsequence

    property p_level_bound;
        @(posedge i_sys_clk) disable iff (i_srst) cnt_r <= scc_pkg::MAX_LEVEL;
    endproperty
    a_level_bound: assert property (p_level_bound) else $error("level counter above four"); // [RULE20]

    property p_open_inc;
        @(posedge i_sys_clk) disable iff (i_srst)
            (i_ce && open_any && free_mask == '0) |=> (cnt_r == $past(cnt_r) + 3'h1);
    endproperty
    a_open_inc: assert property (p_open_inc) else $error("open did not raise level"); // [RULE3]

    property p_resolve_dec;
        @(posedge i_sys_clk) disable iff (i_srst)
            (i_ce && res_good && !fp_done && !open_any) |=> (cnt_r == $past(cnt_r) - 3'h1) && !o_restore_valid;
    endproperty
    a_resolve_dec: assert property (p_resolve_dec) else $error("resolve did not lower level"); // [RULE4]

    property p_restore;
        @(posedge i_sys_clk) disable iff (i_srst)
            (i_ce && res_bad) |=> o_restore_valid && o_flush && (o_fetch_addr == o_restore.alt_fetch);
    endproperty
    a_restore: assert property (p_restore) else $error("mispredict restore missing"); // [RULE6]

    property p_flush_ex;
        @(posedge i_sys_clk) disable iff (i_srst || !i_ce) s_bad_ex |=> o_flush [*4] ##1 !o_flush;
    endproperty
    a_flush_ex: assert property (p_flush_ex) else $error("execute flush length wrong"); // [RULE19]

    property p_flush_wb;
        @(posedge i_sys_clk) disable iff (i_srst || !i_ce) s_bad_wb |=> o_flush [*5] ##1 !o_flush;
    endproperty
    a_flush_wb: assert property (p_flush_wb) else $error("write-back flush length wrong"); // [RULE19]

    property p_no_open_full;
        @(posedge i_sys_clk) disable iff (i_srst)
            (cnt_r == scc_pkg::MAX_LEVEL || wb_cnt_r == scc_pkg::WBUF_MAX || halt_r) |-> !open_any;
    endproperty
    a_no_open_full: assert property (p_no_open_full) else $error("level opened while halted"); // [RULE8]

    property p_hold_spec;
        @(posedge i_sys_clk) disable iff (i_srst)
            (i_ce && wb_cnt_r != '0 && (wb_dep_r[wb_rd_r] & ck_v_r) != '0) |=> !o_mem_wr;
    endproperty
    a_hold_spec: assert property (p_hold_spec) else $error("speculative store released"); // [RULE7]

    property p_fpq_bound;
        @(posedge i_sys_clk) disable iff (i_srst)
            (fq_cnt_r <= scc_pkg::FPQ_MAX) and (i_ce && open_fp |=> o_fpq_push);
    endproperty
    a_fpq_bound: assert property (p_fpq_bound) else $error("fpu queue overrun"); // [RULE15]

    property p_exc_halt;
        @(posedge i_sys_clk) disable iff (i_srst)
            (i_ce && i_int_exc) |=> halt_r || (cnt_r == '0);
    endproperty
    a_exc_halt: assert property (p_exc_halt) else $error("exception did not halt"); // [RULE9]

endmodule

// ### src/scc_pkg.sv
// shared constants and carrier types of the speculation checkpoint control
package scc_pkg;

    localparam int NUM_LEVELS = 4;
    localparam int FPQ_DEPTH = 4;
    localparam int WBUF_DEPTH = 4;
    localparam int SLOT_W = 2;
    localparam int LEVEL_W = 3;
    localparam int PEN_W = 3;

    localparam logic [LEVEL_W-1:0] MAX_LEVEL = 3'h4;
    localparam logic [LEVEL_W-1:0] FPQ_MAX = 3'h4;
    localparam logic [LEVEL_W-1:0] WBUF_MAX = 3'h4;
    localparam logic [LEVEL_W-1:0] LEVEL_RST = 3'h0;
    localparam logic [SLOT_W-1:0] SLOT_RST = 2'h0;

    // refetch penalty, in core clocks, by the stage that resolved the branch
    localparam logic [PEN_W-1:0] PEN_EXECUTE_STAGE = 3'h4;
    localparam logic [PEN_W-1:0] PEN_WRITE_BACK_STAGE = 3'h5;

    localparam int CLK_PERIOD_NS = 5;

    typedef logic [NUM_LEVELS-1:0] scc_mask_t;

    // machine state captured at each speculation level
    typedef struct packed {
        logic [31:0] alt_fetch;
        logic [63:0] regs;
        logic [31:0] flags;
        logic [31:0] env;
    } scc_ckpt_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [63:0] data;
    } scc_store_t;

    typedef struct packed {
        logic valid;
        logic correct;
        logic [SLOT_W-1:0] slot;
        logic in_write_back_stage;
    } scc_resolve_t;

endpackage

// ### tb/scc_fpu_model.sv
// far-side fpu model: completes queued fp instructions after a delay
`timescale 1ns/10ps
module scc_fpu_model
(
    input wire logic i_sys_clk,
    input wire logic i_srst,
    input wire logic i_push,
    input wire logic i_slow,
    output logic o_done
);
    logic [2:0] pend_r;
    logic [3:0] wait_r;

    // one completion per delay, oldest entry first
    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
        begin
            pend_r <= 3'h0;
            wait_r <= 4'h0;
            o_done <= 1'b0;
        end
        else
        begin
            o_done <= 1'b0;
            if (pend_r != 3'h0 && !o_done && wait_r >= (i_slow ? 4'hc : 4'h2))
            begin
                o_done <= 1'b1;
                wait_r <= 4'h0;
                pend_r <= pend_r - 3'h1 + {2'h0, i_push};
            end
            else
            begin
                wait_r <= (pend_r != 3'h0) ? wait_r + 4'h1 : 4'h0;
                pend_r <= pend_r + {2'h0, i_push};
            end
        end
    end
endmodule

// ### tb/tb_scc_ctrl.sv
// self-checking bench for the speculation checkpoint control
`timescale 1ns/10ps
module tb_scc_ctrl;
    logic i_sys_clk, i_srst, i_ce, i_br_open, i_fp_decoded, i_fp_mem_operand, i_fp_ac2, i_fp_mmu_exc;
    logic i_fpu_done, i_fpu_exc, i_int_exc, i_noncp_write, i_st_valid, slow;
    logic [31:0] i_fp_instr;
    scc_pkg::scc_ckpt_t i_ckpt_state;
    scc_pkg::scc_resolve_t i_res;
    scc_pkg::scc_store_t i_st;
    logic o_open_ack, o_spec_stall, o_restore_valid, o_flush, o_fp_pipe_x, o_fp_opnd_req, o_fpq_push;
    logic o_exc_signal, o_mem_wr, o_st_ready;
    logic [scc_pkg::SLOT_W-1:0] o_open_slot;
    logic [scc_pkg::LEVEL_W-1:0] o_spec_level;
    logic [31:0] o_fetch_addr, o_fpq_instr;
    scc_pkg::scc_ckpt_t o_restore;
    scc_pkg::scc_store_t o_mem_st;
    int miscompares = 0;
    int n_tests = 0;
    int ptr = 0;

    scc_ctrl dut (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_ce(i_ce), .i_br_open(i_br_open),
        .i_ckpt_state(i_ckpt_state), .i_fp_decoded(i_fp_decoded), .i_fp_mem_operand(i_fp_mem_operand),
        .i_fp_ac2(i_fp_ac2), .i_fp_mmu_exc(i_fp_mmu_exc), .i_fp_instr(i_fp_instr), .i_res(i_res),
        .i_fpu_done(i_fpu_done), .i_fpu_exc(i_fpu_exc), .i_int_exc(i_int_exc), .i_noncp_write(i_noncp_write),
        .i_st_valid(i_st_valid), .i_st(i_st), .o_open_ack(o_open_ack), .o_open_slot(o_open_slot),
        .o_spec_level(o_spec_level), .o_spec_stall(o_spec_stall), .o_restore_valid(o_restore_valid),
        .o_restore(o_restore), .o_fetch_addr(o_fetch_addr), .o_flush(o_flush), .o_fp_pipe_x(o_fp_pipe_x),
        .o_fp_opnd_req(o_fp_opnd_req), .o_fpq_push(o_fpq_push), .o_fpq_instr(o_fpq_instr),
        .o_exc_signal(o_exc_signal), .o_mem_wr(o_mem_wr), .o_mem_st(o_mem_st), .o_st_ready(o_st_ready));

    scc_fpu_model fpu (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_push(o_fpq_push), .i_slow(slow),
        .o_done(i_fpu_done));

    task automatic end_sim();
        if (miscompares == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_word(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // a bounded wait that ran out ends the run
    task automatic bound_chk(input int n, input int lim);
        if (n >= lim)
        begin
            miscompares++;
            end_sim();
        end
    endtask

    task automatic step();
        @(posedge i_sys_clk);
        #1;
    endtask

    task automatic do_reset();
        @(posedge i_sys_clk);
        i_srst <= 1'b1;
        repeat (3) @(posedge i_sys_clk);
        i_srst <= 1'b0;
        ptr = 0;
    endtask

    task automatic open_br(input logic [31:0] alt, input logic exp);
        @(posedge i_sys_clk);
        i_br_open <= 1'b1;
        i_ckpt_state <= scc_pkg::scc_ckpt_t'{alt, {alt, ~alt}, alt ^ 32'h5a5a_5a5a, ~alt};
        @(posedge i_sys_clk);
        i_br_open <= 1'b0;
        #1;
        chk_bit(o_open_ack, exp);
        if (exp)
        begin
            chk_word(o_open_slot, 64'(ptr));
            ptr = (ptr + 1) % 4;
        end
    endtask

    task automatic resolve(input int slot, input logic ok, input logic wb);
        @(posedge i_sys_clk);
        i_res <= scc_pkg::scc_resolve_t'{1'b1, ok, 2'(slot), wb};
        @(posedge i_sys_clk);
        i_res <= '0;
        #1;
    endtask

    task automatic t_levels();
        int i;
        do_reset();
        #1;
        chk_word(o_spec_level, 64'h0);
        @(posedge i_sys_clk);
        i_br_open <= 1'b1;
        for (i = 0; i < 4; i++)
        begin
            @(posedge i_sys_clk);
            if (i == 3)
                i_br_open <= 1'b0;
            #1;
            chk_bit(o_open_ack, 1'b1);
            chk_word(o_open_slot, 64'(i));
            chk_word(o_spec_level, 64'(i + 1));
        end
        open_br(32'h0, 1'b0);
        chk_bit(o_spec_stall, 1'b1);
        chk_word(o_spec_level, 64'h4);
        for (i = 0; i < 4; i++)
        begin
            resolve(i, 1'b1, 1'b0);
            chk_word(o_spec_level, 64'(3 - i));
            chk_bit(o_restore_valid, 1'b0);
        end
        open_br(32'h0, 1'b1);
    endtask

    task automatic t_mispredict(input logic wb);
        int n;
        do_reset();
        open_br(32'h1000_0040, 1'b1);
        open_br(32'h2000_0080, 1'b1);
        open_br(32'h3000_00c0, 1'b1);
        resolve(1, 1'b0, wb);
        chk_bit(o_restore_valid, 1'b1);
        chk_word(o_fetch_addr, 64'h2000_0080);
        chk_word(o_restore.regs, {32'h2000_0080, ~32'h2000_0080});
        chk_word(64'(o_restore.flags), 64'(32'h2000_0080 ^ 32'h5a5a_5a5a));
        chk_word(o_spec_level, 64'h1);
        n = 0;
        while (o_flush === 1'b1 && n < 10)
        begin
            n++;
            step();
        end
        bound_chk(n, 10);
        chk_word(64'(n), wb ? 64'h5 : 64'h4);
        ptr = 1;
        open_br(32'h0, 1'b1);
    endtask

    task automatic t_stores();
        int i, k;
        do_reset();
        open_br(32'h0, 1'b1);
        @(posedge i_sys_clk);
        i_st_valid <= 1'b1;
        for (i = 0; i < 5; i++)
        begin
            i_st <= scc_pkg::scc_store_t'{32'h0000_0100 + 32'(i * 4), {32'(i), 32'hcafe_0000}};
            @(posedge i_sys_clk);
        end
        i_st_valid <= 1'b0;
        #1;
        chk_bit(o_st_ready, 1'b0);
        chk_bit(o_spec_stall, 1'b1);
        open_br(32'h0, 1'b0);
        for (i = 0; i < 4; i++)
        begin
            chk_bit(o_mem_wr, 1'b0);
            step();
        end
        resolve(0, 1'b1, 1'b0);
        k = 0;
        for (i = 0; i < 20; i++)
        begin
            if (o_mem_wr === 1'b1)
            begin
                chk_word(o_mem_st.addr, 64'h100 + 64'(k * 4));
                chk_word(o_mem_st.data, {32'(k), 32'hcafe_0000});
                k++;
            end
            step();
        end
        chk_word(64'(k), 64'h4);
        open_br(32'h0, 1'b1);
        @(posedge i_sys_clk);
        i_st_valid <= 1'b1;
        @(posedge i_sys_clk);
        i_st_valid <= 1'b0;
        resolve(ptr - 1, 1'b0, 1'b0);
        for (i = 0; i < 12; i++)
        begin
            chk_bit(o_mem_wr, 1'b0);
            step();
        end
    endtask

    task automatic t_fp();
        int n;
        do_reset();
        slow <= 1'b1;
        @(posedge i_sys_clk);
        i_fp_decoded <= 1'b1;
        i_fp_mem_operand <= 1'b1;
        @(posedge i_sys_clk);
        i_fp_decoded <= 1'b0;
        i_fp_mem_operand <= 1'b0;
        #1;
        chk_bit(o_fp_pipe_x, 1'b1);
        chk_bit(o_fp_opnd_req, 1'b1);
        @(posedge i_sys_clk);
        i_fp_ac2 <= 1'b1;
        i_fp_instr <= 32'hd9c0_0001;
        @(posedge i_sys_clk);
        i_fp_ac2 <= 1'b0;
        #1;
        chk_bit(o_fpq_push, 1'b1);
        chk_word(o_fpq_instr, 64'hd9c0_0001);
        chk_word(o_spec_level, 64'h1);
        @(posedge i_sys_clk);
        i_int_exc <= 1'b1;
        @(posedge i_sys_clk);
        i_int_exc <= 1'b0;
        #1;
        chk_bit(o_exc_signal, 1'b0);
        resolve(0, 1'b0, 1'b0);
        chk_word(o_spec_level, 64'h1);
        n = 0;
        while (o_exc_signal !== 1'b1 && n < 40)
        begin
            n++;
            step();
        end
        bound_chk(n, 40);
        chk_word(o_spec_level, 64'h0);
        @(posedge i_sys_clk);
        i_fp_ac2 <= 1'b1;
        i_fp_mem_operand <= 1'b1;
        i_fp_mmu_exc <= 1'b1;
        @(posedge i_sys_clk);
        i_fp_ac2 <= 1'b0;
        i_fp_mem_operand <= 1'b0;
        i_fp_mmu_exc <= 1'b0;
        #1;
        chk_bit(o_fpq_push, 1'b0);
        chk_bit(o_fp_opnd_req, 1'b0);
        slow <= 1'b0;
    endtask

    task automatic t_halt(input int k);
        do_reset();
        open_br(32'h0, 1'b1);
        @(posedge i_sys_clk);
        i_noncp_write <= (k == 0);
        i_fpu_exc <= (k == 1);
        @(posedge i_sys_clk);
        i_noncp_write <= 1'b0;
        i_fpu_exc <= 1'b0;
        #1;
        chk_bit(o_exc_signal, k == 1);
        open_br(32'h0, 1'b0);
        resolve(0, 1'b1, 1'b0);
        open_br(32'h0, 1'b1);
    endtask

    initial
    begin
        i_sys_clk = 1'b0;
        forever #2.5 i_sys_clk = ~i_sys_clk;
    end

    initial
    begin
        i_srst = 1'b1;
        i_ce = 1'b1;
        {i_br_open, i_fp_decoded, i_fp_mem_operand, i_fp_ac2, i_fp_mmu_exc} = 5'h0;
        {i_fpu_exc, i_int_exc, i_noncp_write, i_st_valid, slow} = 5'h0;
        i_fp_instr = 32'h0;
        i_ckpt_state = '0;
        i_res = '0;
        i_st = '0;
        t_levels();
        t_mispredict(1'b0);
        t_mispredict(1'b1);
        t_stores();
        t_fp();
        t_halt(0);
        t_halt(1);
        end_sim();
    end
endmodule
